// ---- inc/flash_sp_pkg.sv ----
// shared constants for the flash self-programming controller and its core end
package flash_sp_pkg;
  // clock rate and programming time window
  localparam int CLK_MHZ = 20; // clk_sys in MHz
  localparam int PROG_MIN_US = 3700; // least programming time, 3.7 ms in us
  localparam int PROG_MAX_US = 4500; // longest programming time, 4.5 ms in us
  localparam int PROG_MIN_CYC = PROG_MIN_US * CLK_MHZ; // least time, whole cycles
  localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ; // longest time, whole cycles
  // address geometry
  localparam int PC_W = 13; // program counter width
  localparam int Z_W = 16; // pointer width
  localparam int PAGE_W = 7; // page select width
  localparam int WORD_W = 6; // word-in-page select width
  localparam int Z_WORD_LO = 1; // pointer bit of the lowest word select bit
  localparam int Z_PAGE_LO = 7; // pointer bit of the lowest page select bit
  localparam int Z_PAGE_HI = 13; // pointer bit of the highest page select bit
  localparam logic [PAGE_W-1:0] RWW_PAGES = 7'h70; // 112 pages below the no-read-while-write area
  localparam logic [13:0] FLASH_WORDS = 14'h2000; // words of flash
  localparam logic [13:0] BOOT_MIN_WORDS = 14'h0080; // boot size for fuse code 11
  // control register bits
  localparam int CB_ENABLE = 0;
  localparam int CB_ERASE = 1;
  localparam int CB_WRITE = 2;
  localparam int CB_LOCK = 3;
  localparam int CB_REEN = 4;
  localparam int CB_BUSY = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK = 8'h1f; // software-writable bits
  // command patterns on control bits 5..0
  localparam logic [5:0] OP_FILL = 6'h01;
  localparam logic [5:0] OP_ERASE = 6'h03;
  localparam logic [5:0] OP_WRITE = 6'h05;
  localparam logic [5:0] OP_LOCK = 6'h09;
  localparam logic [5:0] OP_REEN = 6'h11;
  localparam logic [2:0] SPM_WIN = 3'h4; // cycles in which the store must follow
  localparam logic [7:0] BLOCKED_BYTE = 8'hff; // value read from a blocked region
  // core-end register map, byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ZPTR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_LPM = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_CTRL = 8'h18;
  localparam int ST_OPDONE = 0; // enable flag fell
  localparam int ST_LPMDONE = 1; // program-memory byte arrived
  localparam int ST_W = 2;
endpackage

// ---- inc/flash_sp_if.sv ----
// link between the processor core end and the self-programming controller
`timescale 1ns/1ns
interface flash_sp_if;
  import flash_sp_pkg::*;
  logic ctrlWr; // one-cycle write of the control register
  logic [7:0] ctrlWdata; // control value written
  logic [7:0] ctrlRdata; // live control register contents
  logic spmStb; // one-cycle store-program-memory operation
  logic lpmStb; // one-cycle load-program-memory operation
  logic [Z_W-1:0] zPtr; // pointer for the operation
  logic [15:0] spmData; // word for the page buffer, high byte first register
  logic [7:0] lpmData; // byte read from program memory
  logic lpmValid; // one-cycle pulse, lpmData valid
  modport device (input ctrlWr, ctrlWdata, spmStb, lpmStb, zPtr, spmData,
                  output ctrlRdata, lpmData, lpmValid);
  modport core (output ctrlWr, ctrlWdata, spmStb, lpmStb, zPtr, spmData,
                input ctrlRdata, lpmData, lpmValid);
endinterface

// ---- rtl/prog_timer.sv ----
// countdown that times one flash programming operation
`timescale 1ns/1ns
module prog_timer
  import flash_sp_pkg::*;
#(
  parameter int CYCLES = PROG_MIN_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  typedef struct packed {
    logic [CW-1:0] cnt; // cycles left
  } tmr_s;
  tmr_s st_r;
  tmr_s st_nxt;

  // load on start, count down to zero
  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.cnt = CW'(CYCLES);
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = (st_r.cnt != '0);
  assign done = (st_r.cnt == CW'(1)); // last cycle of the count
endmodule // prog_timer

// ---- rtl/flash_sp_ctrl.sv ----
// device end: self-programming sequencer for the on-chip program flash
`timescale 1ns/1ns
module flash_sp_ctrl
  import flash_sp_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_MIN_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  flash_sp_if.device bus,
  input wire logic [1:0] bootSizeFuse,
  input wire logic eepromWritePending,
  output logic [PC_W-1:0] flashRdAddr,
  input wire logic [15:0] flashRdWord,
  output logic pageErase,
  output logic pageWrite,
  output logic lockWrite,
  output logic [PAGE_W-1:0] pageSel,
  output logic bufWrite,
  output logic [WORD_W-1:0] bufWordSel,
  output logic [15:0] bufData,
  output logic [7:0] lockData,
  output logic progBusy,
  output logic rwRegionReadBlock,
  output logic [PC_W-1:0] bootResetAddr,
  output logic [PC_W-1:0] appEndAddr
);
  typedef struct packed {
    logic [7:0] ctrl; // control register incl. busy flag
    logic [2:0] win; // cycles left for the store
    logic flashOp; // a timed erase or write is running
    logic lockOp; // a timed lock write is running
    logic [1:0] fuseMeta; // fuse synchroniser first stage
    logic [1:0] fuse; // fuse synchroniser second stage
    logic [PC_W-1:0] rdAddr; // word address of the pending read
    logic rdByte; // byte select of the pending read
    logic rdPend; // read waiting for the flash word
    logic [7:0] lpmData; // byte returned to the core
    logic lpmValid; // byte strobe
    logic [PAGE_W-1:0] pageSel;
    logic [WORD_W-1:0] wordSel;
    logic [15:0] bufData;
    logic [7:0] lockData;
    logic bufWr;
    logic eraseStb;
    logic writeStb;
    logic lockStb;
    logic [PC_W-1:0] bootStart;
  } dev_s;
  dev_s st_r;
  dev_s st_nxt;

  logic tmrDone; // last cycle of programming time
  logic tmrStart;
  logic [13:0] bootWords; // boot section size in words
  logic [13:0] bootStartWide;
  logic [15:0] zLive; // pointer with ignored bits cleared

  assign tmrStart = st_r.eraseStb | st_r.writeStb | st_r.lockStb;

  // times every erase, page write and lock write
  prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(tmrStart),
    .busy(),
    .done(tmrDone)
  );

  // boot size doubles per fuse code step down from 11
  always_comb begin
    bootWords = BOOT_MIN_WORDS << (2'h3 - st_r.fuse);
    bootStartWide = FLASH_WORDS - bootWords;
    zLive = {2'h0, bus.zPtr[13:0]};
  end

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.fuseMeta = bootSizeFuse;
    st_nxt.fuse = st_r.fuseMeta;
    st_nxt.bootStart = bootStartWide[PC_W-1:0];
    st_nxt.bufWr = 1'b0;
    st_nxt.eraseStb = 1'b0;
    st_nxt.writeStb = 1'b0;
    st_nxt.lockStb = 1'b0;
    st_nxt.lpmValid = 1'b0;
    // store window runs down
    if (st_r.win != 3'h0) begin
      st_nxt.win = st_r.win - 3'h1;
      if (st_r.win == 3'h1) begin
        st_nxt.ctrl[5:0] = 6'h00;
      end
    end
    // control write, ignored while a command is still open
    if (bus.ctrlWr && !st_r.ctrl[CB_ENABLE]) begin
      st_nxt.ctrl[5:0] = bus.ctrlWdata[5:0] & CTRL_WR_MASK[5:0];
      st_nxt.win = bus.ctrlWdata[CB_ENABLE] ? SPM_WIN : 3'h0;
    end else if (bus.spmStb && st_r.win != 3'h0) begin
      st_nxt.win = 3'h0;
      st_nxt.ctrl[5:0] = 6'h00;
      if (eepromWritePending) begin
        // command dropped, flash untouched
        st_nxt.ctrl[5:0] = 6'h00;
      end else begin
        unique case (st_r.ctrl[5:0])
          OP_FILL: begin
            st_nxt.wordSel = zLive[Z_PAGE_LO-1:Z_WORD_LO];
            st_nxt.bufData = bus.spmData;
            st_nxt.bufWr = 1'b1;
          end
          OP_ERASE, OP_WRITE: begin
            st_nxt.pageSel = zLive[Z_PAGE_HI:Z_PAGE_LO];
            st_nxt.eraseStb = (st_r.ctrl[5:0] == OP_ERASE);
            st_nxt.writeStb = (st_r.ctrl[5:0] == OP_WRITE);
            st_nxt.flashOp = 1'b1;
            st_nxt.ctrl[5:0] = st_r.ctrl[5:0];
            st_nxt.ctrl[CB_BUSY] = 1'b1;
          end
          OP_LOCK: begin
            st_nxt.lockData = bus.spmData[7:0];
            st_nxt.lockStb = 1'b1;
            st_nxt.lockOp = 1'b1;
            st_nxt.ctrl[5:0] = st_r.ctrl[5:0];
          end
          OP_REEN: begin
            // re-enable only once programming has finished
            if (!st_r.flashOp) begin
              st_nxt.ctrl[CB_BUSY] = 1'b0;
            end
          end
          default: begin
            st_nxt.ctrl[5:0] = 6'h00;
          end
        endcase
      end
    end
    // timed operation over: release the enable flag
    if (tmrDone) begin
      st_nxt.ctrl[5:0] = 6'h00;
      st_nxt.flashOp = 1'b0;
      st_nxt.lockOp = 1'b0;
    end
    // program-memory read, two cycles
    if (bus.lpmStb) begin
      st_nxt.rdAddr = zLive[PC_W:1];
      st_nxt.rdByte = zLive[0];
      st_nxt.rdPend = 1'b1;
    end else begin
      st_nxt.rdPend = 1'b0;
    end
    if (st_r.rdPend) begin
      st_nxt.lpmValid = 1'b1;
      if (st_r.flashOp && st_r.rdAddr[PC_W-1:WORD_W] < RWW_PAGES) begin
        st_nxt.lpmData = BLOCKED_BYTE;
      end else begin
        st_nxt.lpmData = st_r.rdByte ? flashRdWord[15:8] : flashRdWord[7:0];
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RESET;
      // synchroniser starts at code 11 so the boot vector does not jump after reset
      st_r.fuseMeta <= 2'h3;
      st_r.fuse <= 2'h3;
      st_r.bootStart <= FLASH_WORDS[PC_W-1:0] - BOOT_MIN_WORDS[PC_W-1:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs from flip-flops; progBusy and appEndAddr through logic after them
  assign bus.ctrlRdata = st_r.ctrl;
  assign bus.lpmData = st_r.lpmData;
  assign bus.lpmValid = st_r.lpmValid;
  assign flashRdAddr = st_r.rdAddr;
  assign pageErase = st_r.eraseStb;
  assign pageWrite = st_r.writeStb;
  assign lockWrite = st_r.lockStb;
  assign pageSel = st_r.pageSel;
  assign bufWrite = st_r.bufWr;
  assign bufWordSel = st_r.wordSel;
  assign bufData = st_r.bufData;
  assign lockData = st_r.lockData;
  assign progBusy = st_r.flashOp | st_r.lockOp;
  assign rwRegionReadBlock = st_r.flashOp;
  assign bootResetAddr = st_r.bootStart;
  assign appEndAddr = st_r.bootStart - 13'h0001;
endmodule // flash_sp_ctrl

// ---- rtl/flash_sp_core.sv ----
// core end: issues self-programming commands on behalf of software over Avalon-MM
`timescale 1ns/1ns
module flash_sp_core
  import flash_sp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  flash_sp_if.core bus,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic eepromWritePending,
  output logic irq
);
  typedef struct packed {
    logic [15:0] zReg; // software pointer
    logic [15:0] dataReg; // word for buffer fill or lock data
    logic [15:0] zOut; // pointer sent on the link
    logic [15:0] dataOut;
    logic [7:0] ctrlOut;
    logic ctrlWr;
    logic spmPend; // store follows the control write
    logic spmStb;
    logic lpmStb;
    logic [7:0] lpmByte; // last byte read
    logic [ST_W-1:0] status; // sticky events
    logic [ST_W-1:0] mask;
    logic enPrev; // enable flag last cycle
    logic [31:0] rdData;
    logic rdAck;
  } core_s;
  core_s st_r;
  core_s st_nxt;

  logic linkIdle; // no command in flight
  logic cmdReady; // a command may be sent now
  logic [ST_W-1:0] evt;

  always_comb begin
    linkIdle = !st_r.ctrlWr && !st_r.spmPend && !st_r.spmStb && !st_r.lpmStb;
    cmdReady = linkIdle && !bus.ctrlRdata[CB_ENABLE] && !eepromWritePending;
    evt = '0;
    evt[ST_OPDONE] = st_r.enPrev && !bus.ctrlRdata[CB_ENABLE];
    evt[ST_LPMDONE] = bus.lpmValid;
  end

  // command stalls until the previous one has closed; reads take one wait cycle
  always_comb begin
    waitrequest = 1'b0;
    if (read) begin
      waitrequest = !st_r.rdAck;
    end else if (write && address == REG_CMD) begin
      waitrequest = !cmdReady;
    end else if (write && address == REG_LPM) begin
      waitrequest = !linkIdle;
    end
  end

  // register and link next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.ctrlWr = 1'b0;
    st_nxt.spmStb = 1'b0;
    st_nxt.lpmStb = 1'b0;
    st_nxt.enPrev = bus.ctrlRdata[CB_ENABLE];
    st_nxt.rdAck = 1'b0;
    // store issued the cycle after the control write
    if (st_r.spmPend) begin
      st_nxt.spmStb = 1'b1;
      st_nxt.spmPend = 1'b0;
    end
    if (bus.lpmValid) begin
      st_nxt.lpmByte = bus.lpmData;
    end
    // sticky events: set beats a clear in the same cycle
    st_nxt.status = st_r.status;
    if (write && !waitrequest && address == REG_STATUS) begin
      st_nxt.status = st_r.status & ~writedata[ST_W-1:0];
    end
    st_nxt.status = st_nxt.status | evt;
    if (write && !waitrequest) begin
      unique case (address)
        REG_ZPTR: st_nxt.zReg = writedata[15:0];
        REG_DATA: st_nxt.dataReg = writedata[15:0];
        REG_MASK: st_nxt.mask = writedata[ST_W-1:0];
        REG_CMD: begin
          st_nxt.ctrlOut = writedata[7:0];
          st_nxt.ctrlWr = 1'b1;
          st_nxt.spmPend = 1'b1;
          st_nxt.dataOut = st_r.dataReg;
          st_nxt.zOut = {st_r.zReg[15:1], 1'b0};
          if (writedata[5:0] == OP_WRITE) begin
            st_nxt.zOut[Z_PAGE_LO-1:0] = 7'h00;
          end
        end
        REG_LPM: begin
          st_nxt.zOut = st_r.zReg;
          st_nxt.lpmStb = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // read data latched in the wait cycle
    if (read && !st_r.rdAck) begin
      st_nxt.rdAck = 1'b1;
      unique case (address)
        REG_ZPTR: st_nxt.rdData = {16'h0000, st_r.zReg};
        REG_DATA: st_nxt.rdData = {16'h0000, st_r.dataReg};
        REG_LPM: st_nxt.rdData = {24'h000000, st_r.lpmByte};
        REG_STATUS: st_nxt.rdData = {{(32-ST_W){1'b0}}, st_r.status};
        REG_MASK: st_nxt.rdData = {{(32-ST_W){1'b0}}, st_r.mask};
        REG_CTRL: st_nxt.rdData = {24'h000000, bus.ctrlRdata};
        default: st_nxt.rdData = 32'h00000000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign readdata = st_r.rdData;
  assign irq = |(st_r.status & st_r.mask);
  assign bus.ctrlWr = st_r.ctrlWr;
  assign bus.ctrlWdata = st_r.ctrlOut;
  assign bus.spmStb = st_r.spmStb;
  assign bus.lpmStb = st_r.lpmStb;
  assign bus.zPtr = st_r.zOut;
  assign bus.spmData = st_r.dataOut;
endmodule // flash_sp_core

// ---- bench/flash_sp_checker.sv ----
// concurrent checks on the link between the core end and the controller
`timescale 1ns/1ns
module flash_sp_checker
  import flash_sp_pkg::*;
#(
  parameter int PROG_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ctrlWr,
  input wire logic [7:0] ctrlRdata,
  input wire logic spmStb,
  input wire logic lpmStb,
  input wire logic [Z_W-1:0] zPtr,
  input wire logic lpmValid,
  input wire logic eepromWritePending
);
  localparam int END_LAST = PROG_CYCLES + 1; // cycles from the store to the last cycle with enable set
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // store launching an erase, write or lock
  logic timedOp;
  assign timedOp = spmStb && !eepromWritePending && (ctrlRdata[5:0] == OP_ERASE || ctrlRdata[5:0] == OP_WRITE
                   || ctrlRdata[5:0] == OP_LOCK);
  a_store_follows_ctrl: assert property (ctrlWr |=> spmStb)
    else $error("store did not follow control write");
  a_cmd_when_idle: assert property (ctrlWr |-> !ctrlRdata[CB_ENABLE])
    else $error("command issued while enable set");
  a_store_bit0_zero: assert property (spmStb |-> !zPtr[0])
    else $error("store with pointer bit 0 set");
  a_write_word_zero: assert property (spmStb && ctrlRdata[5:0] == OP_WRITE |-> zPtr[6:0] == 7'h00)
    else $error("page write with word select set");
  a_busy_on_prog: assert property (spmStb && !eepromWritePending
    && (ctrlRdata[5:0] == OP_ERASE || ctrlRdata[5:0] == OP_WRITE)
    |=> ctrlRdata[CB_BUSY] && ctrlRdata[CB_ENABLE])
    else $error("busy flag not set by erase or write");
  a_enable_holds: assert property (timedOp |=> ctrlRdata[CB_ENABLE] [*8])
    else $error("enable cleared early");
  a_prog_ends: assert property (timedOp |-> ##END_LAST ctrlRdata[CB_ENABLE] ##1 !ctrlRdata[CB_ENABLE])
    else $error("timed operation length wrong");
  a_reenable_clears: assert property (spmStb && ctrlRdata[5:0] == OP_REEN |=> !ctrlRdata[CB_BUSY])
    else $error("re-enable left busy flag set");
  a_lpm_answer: assert property (lpmStb |-> ##2 lpmValid)
    else $error("program byte late");
endmodule // flash_sp_checker

// ---- bench/flash_self_program_control_tb_top.sv ----
// bench joining core end and controller, driven over Avalon-MM
`timescale 1ns/1ns
module flash_self_program_control_tb_top;
  import flash_sp_pkg::*;
  localparam int PROG = 20; // shortened programming time
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic eepromWritePending = 1'b0;
  logic irq;
  logic [1:0] bootSizeFuse = 2'h3;
  logic [PC_W-1:0] flashRdAddr, bootResetAddr, appEndAddr;
  logic [15:0] flashRdWord, bufData;
  logic pageErase, pageWrite, lockWrite, bufWrite, progBusy, rwRegionReadBlock;
  logic [PAGE_W-1:0] pageSel;
  logic [WORD_W-1:0] bufWordSel;
  logic [7:0] lockData;
  int miscompares = 0;
  int nCompared = 0;
  logic [3:0] evt; // pulse outputs by index
  assign evt = {pageErase, pageWrite, lockWrite, bufWrite};
  // flash array stand-in: word value tells its address
  assign flashRdWord = {3'h5, flashRdAddr};
  always #25 clk_sys = ~clk_sys;
  flash_sp_if linkIf ();
  flash_sp_core u_flash_sp_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(linkIf), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .eepromWritePending(eepromWritePending), .irq(irq));
  flash_sp_ctrl #(.PROG_CYCLES(PROG)) u_flash_sp_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(linkIf),
    .bootSizeFuse(bootSizeFuse), .eepromWritePending(eepromWritePending), .flashRdAddr(flashRdAddr),
    .flashRdWord(flashRdWord), .pageErase(pageErase), .pageWrite(pageWrite), .lockWrite(lockWrite),
    .pageSel(pageSel), .bufWrite(bufWrite), .bufWordSel(bufWordSel), .bufData(bufData),
    .lockData(lockData), .progBusy(progBusy), .rwRegionReadBlock(rwRegionReadBlock),
    .bootResetAddr(bootResetAddr), .appEndAddr(appEndAddr));
  flash_sp_checker #(.PROG_CYCLES(PROG)) u_flash_sp_checker (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .ctrlWr(linkIf.ctrlWr), .ctrlRdata(linkIf.ctrlRdata), .spmStb(linkIf.spmStb),
    .lpmStb(linkIf.lpmStb), .zPtr(linkIf.zPtr), .lpmValid(linkIf.lpmValid),
    .eepromWritePending(eepromWritePending));
  // verdict and end of run
  task automatic end_sim();
    if (miscompares == 0 && nCompared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // compare and report a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one Avalon transfer, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 2000);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    chk(n < 2000, 32'h1, "bus wait");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string w);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    chk(q, e, w);
  endtask
  // read control register until the enable bit clears
  task automatic pollCtrl(output logic [31:0] q);
    int n;
    n = 0;
    do begin
      av(1'b0, REG_CTRL, 32'h0, q);
      n++;
    end while (q[CB_ENABLE] !== 1'b0 && n < 60);
    chk(n < 60, 32'h1, "enable stuck");
  endtask
  // wait for a pulse output, bounded
  task automatic waitEvt(input int i);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (evt[i] !== 1'b1 && n < 200);
    chk(n < 200, 32'h1, "pulse missing");
  endtask
  // every boot-size code moves boot vector and application end
  task automatic fuseScan();
    logic [12:0] bootTbl [4];
    bootTbl = '{13'h1c00, 13'h1e00, 13'h1f00, 13'h1f80}; // boot start for codes 00..11
    for (int c = 3; c >= 0; c--) begin
      @(posedge clk_sys);
      bootSizeFuse <= 2'(c);
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(bootResetAddr, bootTbl[c], "boot vector");
      chk(appEndAddr, bootTbl[c] - 13'h1, "app end");
    end
  endtask
  // buffer fill: word select from pointer bits 6..1, top bits and bit 0 ignored
  task automatic fillWord();
    wr(REG_ZPTR, 32'hc05b);
    wr(REG_DATA, 32'hbeef);
    wr(REG_CMD, {26'h0, OP_FILL});
    waitEvt(0);
    chk(bufWordSel, 6'h2d, "word select");
    chk(bufData, 16'hbeef, "buffer word");
  endtask
  // erase, write or lock: page, block, timing, done flag, busy and re-enable
  task automatic timedOp(input logic [5:0] cmd, input logic [15:0] z, input int i, input logic [7:0] e,
                         input logic [7:0] lb);
    int n;
    time t0;
    logic [31:0] q;
    n = 0;
    wr(REG_STATUS, 32'h3);
    wr(REG_ZPTR, {16'h0, z});
    wr(REG_CMD, {26'h0, cmd});
    waitEvt(i);
    t0 = $time;
    chk((cmd == OP_LOCK) ? lockData : pageSel, e, "page or lock");
    chk(rwRegionReadBlock, cmd != OP_LOCK, "read block");
    // program byte read at the pointer while the operation runs
    wr(REG_LPM, 32'h0);
    repeat (4) @(posedge clk_sys);
    rdChk(REG_LPM, {24'h0, lb}, "read while programming");
    while (progBusy === 1'b1 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(32'(($time - t0) / 50), PROG + 1, "op time");
    pollCtrl(q);
    chk(q, (cmd == OP_LOCK) ? 32'h0 : 32'h40, "busy after op");
    rdChk(REG_STATUS, 32'h3, "op done");
    chk(irq, 1'b1, "irq raised");
    wr(REG_STATUS, 32'h1);
    @(negedge clk_sys);
    chk(irq, 1'b0, "irq cleared");
    wr(REG_CMD, {26'h0, OP_REEN});
    pollCtrl(q);
    chk(q, 32'h0, "busy after re-enable");
  endtask
  // command held back while an eeprom write is pending
  task automatic eepromHold();
    int hits;
    logic [31:0] q;
    hits = 0;
    @(posedge clk_sys);
    eepromWritePending <= 1'b1;
    fork
      wr(REG_CMD, {26'h0, OP_ERASE});
      begin
        repeat (20) begin
          @(negedge clk_sys);
          if (pageErase === 1'b1) hits++;
        end
        @(posedge clk_sys);
        eepromWritePending <= 1'b0;
      end
    join
    chk(hits, 32'h0, "erase during eeprom write");
    waitEvt(3);
    pollCtrl(q);
    wr(REG_CMD, {26'h0, OP_REEN});
    pollCtrl(q);
    // eeprom write starts between control write and store: device drops the store
    wr(REG_CMD, {26'h0, OP_ERASE});
    eepromWritePending <= 1'b1;
    hits = 0;
    repeat (6) begin
      @(negedge clk_sys);
      if (pageErase === 1'b1) hits++;
    end
    @(posedge clk_sys);
    eepromWritePending <= 1'b0;
    chk(hits, 32'h0, "erase not dropped");
    rdChk(REG_CTRL, 32'h0, "dropped command");
  endtask
  // program byte read: bit 0 picks high or low byte
  task automatic lpmRead();
    for (int b = 0; b < 2; b++) begin
      wr(REG_STATUS, 32'h3);
      wr(REG_ZPTR, 32'he468 | b);
      wr(REG_LPM, 32'h0);
      repeat (6) @(posedge clk_sys);
      rdChk(REG_STATUS, 32'h2, "byte arrived");
      chk(irq, 1'b0, "masked irq");
      rdChk(REG_LPM, b ? 32'hb2 : 32'h34, "program byte");
    end
  endtask
  // watchdog
  initial begin
    #2000000;
    miscompares++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    chk(bootResetAddr, 13'h1f80, "reset boot vector");
    @(negedge clk_sys);
    chk(bootResetAddr, 13'h1f80, "boot vector after reset");
    chk(appEndAddr, 13'h1f7f, "app end after reset");
    rdChk(REG_MASK, 32'h0, "mask reset");
    rdChk(8'hfc, 32'h0, "unmapped read");
    wr(8'hfc, 32'hffff);
    wr(REG_MASK, 32'h1);
    rdChk(REG_MASK, 32'h1, "mask");
    fuseScan();
    fillWord();
    wr(REG_DATA, 32'hc3);
    timedOp(OP_ERASE, 16'hea80, 3, 8'h55, 8'hff);
    timedOp(OP_WRITE, 16'hfabf, 2, 8'h75, 8'hbd);
    timedOp(OP_LOCK, 16'h0001, 1, 8'hc3, 8'ha0);
    eepromHold();
    lpmRead();
    end_sim();
  end
endmodule // flash_self_program_control_tb_top
